// [rtl/ppg_pkg.sv]
// Purpose: Shared constants for the printer port with general I/O.
// Assumes: Host bus and printer pins are asynchronous to core_clk_i.
// Notes: Register indices are the host address lines A1..A0.
package ppg_pkg;
    localparam logic [1:0] PPG_ADDR_DATA = 2'h0;
    localparam logic [1:0] PPG_ADDR_STATUS = 2'h1;
    localparam logic [1:0] PPG_ADDR_CTRL = 2'h2;
    localparam logic [1:0] PPG_ADDR_GPIO = 2'h3;
    // Control register fields.
    localparam int PPG_CTL_STROBE = 0;
    localparam int PPG_CTL_AUTOLF = 1;
    localparam int PPG_CTL_RESTART_N = 2;
    localparam int PPG_CTL_SELIN = 3;
    localparam int PPG_CTL_IRQEN = 4;
    localparam int PPG_CTL_TURN = 5;
    // Status register fields.
    localparam int PPG_ST_IRQ_N = 2;
    localparam int PPG_ST_FAULT = 3;
    localparam int PPG_ST_BUSY = 7;
    localparam logic [1:0] PPG_ST_LOW_ONES = 2'h3;
    localparam logic [1:0] PPG_CTL_HIGH_ONES = 2'h3;
    // Reset values: restart line negated (bit 2 set), all else clear.
    localparam logic [4:0] PPG_CTL_RESET = 5'h04;
    localparam logic [7:0] PPG_DATA_RESET = 8'h00;
    // General I/O layout: 0-2 inputs, 3-4 bidirectional, 5-6 outputs.
    localparam logic [6:0] PPG_GP_WRITABLE = 7'h78;
    localparam logic [6:0] PPG_GP_OUT_FIXED = 7'h60;
    localparam logic [6:0] PPG_GP_RESET = 7'h00;
    localparam logic [1:0] PPG_GP_DIR_RESET = 2'h0;
    localparam int PPG_BUF_DEPTH = 2;
endpackage : ppg_pkg

// [rtl/ppg_wr_if.sv]
`timescale 1ns/1ns
// Purpose: Carries accepted host writes from capture to the register file.
// Assumes: One clock domain.
// Notes: Valid and ready handshake on each side of the buffer.
interface ppg_wr_if;
    logic valid;
    logic ready;
    logic [1:0] addr;
    logic [7:0] data;
    modport src (output valid, output addr, output data, input ready);
    modport dst (input valid, input addr, input data, output ready);
endinterface : ppg_wr_if

// [rtl/ppg_wr_buf.sv]
`timescale 1ns/1ns
// Purpose: Two-entry buffer for host write words.
// Assumes: Source and sink share core_clk_i.
// Notes: Honest full and empty; a stalled sink fills it.
module ppg_wr_buf
    import ppg_pkg::*;
(
    // Clock and reset
    input wire logic core_clk_i,
    input wire logic rstn_i,
    // Fill and drain sides
    ppg_wr_if.dst in_if,
    ppg_wr_if.src out_if
);
    logic [9:0] mem_q [PPG_BUF_DEPTH];
    logic wp_q;
    logic rp_q;
    logic [1:0] cnt_q;
    logic push;
    logic pop;

    assign in_if.ready = (cnt_q != 2'(PPG_BUF_DEPTH));
    assign out_if.valid = (cnt_q != 2'h0);
    assign out_if.addr = mem_q[rp_q][9:8];
    assign out_if.data = mem_q[rp_q][7:0];
    assign push = in_if.valid && in_if.ready;
    assign pop = out_if.valid && out_if.ready;

    always_ff @(posedge core_clk_i) begin
        if (push) begin
            mem_q[wp_q] <= {in_if.addr, in_if.data};
        end
    end

    always_ff @(posedge core_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            wp_q <= 1'b0;
            rp_q <= 1'b0;
            cnt_q <= 2'h0;
        end else begin
            if (push) begin
                wp_q <= ~wp_q;
            end
            if (pop) begin
                rp_q <= ~rp_q;
            end
            cnt_q <= cnt_q + 2'(push) - 2'(pop);
        end
    end
endmodule : ppg_wr_buf

// [rtl/ppg_top.sv]
`timescale 1ns/1ns
// Purpose: Host-addressed printer port with general purpose I/O register.
// Assumes: Host strobes, address, data and printer inputs are asynchronous.
// Notes: Host data bus and pin buses are split into in, out and enable.
module ppg_top
    import ppg_pkg::*;
(
    // Clock and reset
    input wire logic core_clk_i,
    input wire logic rstn_i,
    // Host bus
    input wire logic port_select_n_i,
    input wire logic host_read_strobe_n_i,
    input wire logic host_write_strobe_n_i,
    input wire logic [1:0] host_addr_i,
    input wire logic [7:0] host_data_i,
    output logic [7:0] host_data_o,
    output logic host_data_oe_n_o,
    // Mode straps
    input wire logic extended_mode_pin_i,
    input wire logic simple_variant_i,
    input wire logic latch_drive_enable_n_i,
    input wire logic gpio_config_done_i,
    // Printer data lines
    input wire logic [7:0] printer_data_lines_i,
    output logic [7:0] printer_data_lines_o,
    output logic printer_data_lines_oe_n_o,
    // Printer control outputs, active high
    output logic printer_strobe_o,
    output logic auto_linefeed_o,
    output logic printer_restart_o,
    output logic printer_select_in_o,
    // Printer status inputs and acknowledge interrupt output
    input wire logic printer_fault_n_i,
    input wire logic printer_online_i,
    input wire logic paper_out_i,
    input wire logic printer_ack_n_i,
    input wire logic printer_busy_i,
    output logic ack_irq_o,
    // General I/O lines
    input wire logic [6:0] gp_lines_i,
    output logic [6:0] gp_lines_o,
    output logic [6:0] gp_lines_oe_n_o
);
    localparam int NSYNC = 17;

    // Raw asynchronous inputs gathered for one synchroniser bank.
    logic [NSYNC-1:0] raw;
    logic [NSYNC-1:0] s1_q;
    logic [NSYNC-1:0] s2_q;
    assign raw = {port_select_n_i, host_read_strobe_n_i,
                  host_write_strobe_n_i, extended_mode_pin_i,
                  latch_drive_enable_n_i, printer_fault_n_i,
                  printer_online_i, paper_out_i, printer_ack_n_i,
                  printer_busy_i, gp_lines_i};

    genvar gi;
    generate
        for (gi = 0; gi < NSYNC; gi++) begin : g_sync
            always_ff @(posedge core_clk_i or negedge rstn_i) begin
                if (!rstn_i) begin
                    s1_q[gi] <= 1'b1;
                    s2_q[gi] <= 1'b1;
                end else begin
                    s1_q[gi] <= raw[gi];
                    s2_q[gi] <= s1_q[gi];
                end
            end
        end
    endgenerate

    logic sel_n;
    logic rd_n;
    logic wr_n;
    logic ext_mode;
    logic drive_n;
    logic fault_n;
    logic online;
    logic pout;
    logic ack_n;
    logic busy;
    logic [6:0] gp_in;
    assign {sel_n, rd_n, wr_n, ext_mode, drive_n, fault_n, online, pout,
            ack_n, busy, gp_in} = s2_q;

    // Address and data are stable around the strobe; two flops suffice.
    logic [9:0] ad1_q;
    logic [9:0] ad2_q;
    logic [7:0] pd1_q;
    logic [7:0] pd2_q;
    always_ff @(posedge core_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            ad1_q <= 10'h000;
            ad2_q <= 10'h000;
        end else begin
            ad1_q <= {host_addr_i, host_data_i};
            ad2_q <= ad1_q;
        end
    end

    // Printer data line levels, read back when the latch is released.
    always_ff @(posedge core_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            pd1_q <= 8'h00;
            pd2_q <= 8'h00;
        end else begin
            pd1_q <= printer_data_lines_i;
            pd2_q <= pd1_q;
        end
    end

    // Previous strobe levels for edge detection.
    logic rd_n_q;
    logic wr_n_q;
    logic ack_n_q;
    always_ff @(posedge core_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            rd_n_q <= 1'b1;
            wr_n_q <= 1'b1;
        end else begin
            rd_n_q <= rd_n;
            wr_n_q <= wr_n;
        end
    end

    // Previous acknowledge level; idle high so reset shows no release.
    always_ff @(posedge core_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            ack_n_q <= 1'b1;
        end else begin
            ack_n_q <= ack_n;
        end
    end

    logic rd_start;
    logic rd_end;
    logic wr_fire;
    assign rd_start = !sel_n && !rd_n && rd_n_q;
    assign rd_end = rd_n && !rd_n_q;
    assign wr_fire = !sel_n && wr_n && !wr_n_q;

    // Writes are taken on the strobe's rising edge and buffered.
    ppg_wr_if wq_in ();
    ppg_wr_if wq_out ();
    assign wq_in.valid = wr_fire;
    assign wq_in.addr = ad2_q[9:8];
    assign wq_in.data = ad2_q[7:0];
    assign wq_out.ready = 1'b1;

    ppg_wr_buf u_wr_buf (
        .core_clk_i(core_clk_i),
        .rstn_i(rstn_i),
        .in_if(wq_in),
        .out_if(wq_out)
    );

    logic wr_ok;
    assign wr_ok = wq_out.valid && wq_out.ready;

    function automatic logic wr_hits(input logic ok, input logic [1:0] a,
                                     input logic [1:0] want);
        wr_hits = ok && (a == want);
    endfunction : wr_hits

    // Register state.
    logic [7:0] data_q;
    logic [4:0] ctl_q;
    logic turn_q;
    logic [6:0] gp_q;
    logic [1:0] gp_dir_q;
    logic irq_n_q;

    // latch always loads on data write
    always_ff @(posedge core_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            data_q <= PPG_DATA_RESET;
        end else if (wr_hits(wr_ok, wq_out.addr, PPG_ADDR_DATA)) begin
            data_q <= wq_out.data;
        end
    end

    always_ff @(posedge core_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            ctl_q <= PPG_CTL_RESET;
        end else if (wr_hits(wr_ok, wq_out.addr, PPG_ADDR_CTRL)) begin
            ctl_q <= wq_out.data[4:0];
        end
    end

    always_ff @(posedge core_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            turn_q <= 1'b0;
        end else if (wr_hits(wr_ok, wq_out.addr, PPG_ADDR_CTRL)) begin
            turn_q <= wq_out.data[PPG_CTL_TURN];
        end
    end

    always_ff @(posedge core_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            gp_q <= PPG_GP_RESET;
        end else if (gpio_config_done_i &&
                     wr_hits(wr_ok, wq_out.addr, PPG_ADDR_GPIO)) begin
            gp_q <= (wq_out.data[6:0] & PPG_GP_WRITABLE) |
                    (gp_q & ~PPG_GP_WRITABLE);
        end
    end

    always_ff @(posedge core_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            gp_dir_q <= PPG_GP_DIR_RESET;
        end else if (gpio_config_done_i &&
                     wr_hits(wr_ok, wq_out.addr, PPG_ADDR_GPIO)) begin
            gp_dir_q <= wq_out.data[4:3];
        end
    end

    // A release in the same cycle as a status read wins, so that no
    // acknowledge is lost to a read that was already under way.
    // flag cleared on acknowledge release
    // status read sets flag, event wins
    always_ff @(posedge core_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            irq_n_q <= 1'b1;
        end else if (ack_n && !ack_n_q && ctl_q[PPG_CTL_IRQEN]) begin
            irq_n_q <= 1'b0;
        end else if (rd_start && ad2_q[9:8] == PPG_ADDR_STATUS) begin
            irq_n_q <= 1'b1;
        end
    end

    logic released;
    assign released = simple_variant_i ? drive_n : (ext_mode && turn_q);

    // Read multiplexer.
    logic [7:0] rd_val;
    always_comb begin
        rd_val = 8'h00;
        case (ad2_q[9:8])
            PPG_ADDR_DATA: rd_val = released ? pd2_q : data_q;
            // fixed ones in bits 0 and 1
            PPG_ADDR_STATUS: rd_val = {!busy, ack_n, pout, online, fault_n,
                                       irq_n_q, PPG_ST_LOW_ONES};
            PPG_ADDR_CTRL: rd_val = {PPG_CTL_HIGH_ONES, 1'b1, ctl_q};
            PPG_ADDR_GPIO: rd_val = gpio_config_done_i ?
                {1'b0, gp_q[6:5],
                 (gp_dir_q & gp_q[4:3]) | (~gp_dir_q & gp_in[4:3]),
                 gp_in[2:0]} : 8'h00;
            default: rd_val = 8'h00;
        endcase
    end

    // Host data bus is driven for the length of a selected read.
    always_ff @(posedge core_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            host_data_o <= 8'h00;
            host_data_oe_n_o <= 1'b1;
        end else begin
            if (rd_start) begin
                host_data_o <= rd_val;
                host_data_oe_n_o <= 1'b0;
            end else if (rd_end || sel_n) begin
                host_data_oe_n_o <= 1'b1;
            end
        end
    end

    // Printer data pins.
    always_ff @(posedge core_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            printer_data_lines_o <= PPG_DATA_RESET;
            printer_data_lines_oe_n_o <= 1'b0;
        end else begin
            printer_data_lines_o <= data_q;
            printer_data_lines_oe_n_o <= released;
        end
    end

    // Printer control lines.
    always_ff @(posedge core_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            printer_strobe_o <= 1'b0;
            auto_linefeed_o <= 1'b0;
            printer_restart_o <= 1'b0;
            printer_select_in_o <= 1'b0;
        end else begin
            printer_strobe_o <= ctl_q[PPG_CTL_STROBE];
            auto_linefeed_o <= ctl_q[PPG_CTL_AUTOLF];
            printer_select_in_o <= ctl_q[PPG_CTL_SELIN];
            printer_restart_o <= !ctl_q[PPG_CTL_RESTART_N];
        end
    end

    always_ff @(posedge core_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            ack_irq_o <= 1'b0;
        end else begin
            ack_irq_o <= !irq_n_q && ctl_q[PPG_CTL_IRQEN];
        end
    end

    // General I/O pins: outputs driven once gpio_config_done_i is set, bidirectional per direction; all released before.
    always_ff @(posedge core_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            gp_lines_o <= PPG_GP_RESET;
            gp_lines_oe_n_o <= 7'h7F;
        end else begin
            gp_lines_o <= gp_q;
            gp_lines_oe_n_o <= gpio_config_done_i ?
                ~(PPG_GP_OUT_FIXED | {2'h0, gp_dir_q, 3'h0}) : 7'h7F;
        end
    end
endmodule : ppg_top

// [dv/ppg_top_asserts.sv]
// Purpose: Port-level assertions for the printer port with general I/O.
// Assumes: One clock domain; host and printer inputs pass two flops.
// Notes: Windows leave room for the input synchronisers.
`timescale 1ns/1ns
module ppg_top_asserts
    import ppg_pkg::*;
(
    // Clock and reset
    input wire logic core_clk_i,
    input wire logic rstn_i,
    // Host bus
    input wire logic port_select_n_i,
    input wire logic host_read_strobe_n_i,
    input wire logic [1:0] host_addr_i,
    input wire logic host_data_oe_n_o,
    // Modes and data pins
    input wire logic extended_mode_pin_i,
    input wire logic simple_variant_i,
    input wire logic latch_drive_enable_n_i,
    input wire logic printer_data_lines_oe_n_o,
    // Printer handshake and control
    input wire logic printer_strobe_o,
    input wire logic printer_restart_o,
    input wire logic printer_ack_n_i,
    input wire logic ack_irq_o,
    // General I/O
    input wire logic [6:0] gp_lines_oe_n_o
);
    default clocking cb @(posedge core_clk_i);
    endclocking
    default disable iff (!rstn_i);

    logic ack_q;
    logic [3:0] since_ack_q;

    // Counts cycles since the acknowledge line was released.
    always_ff @(posedge core_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            ack_q <= 1'b1;
            since_ack_q <= 4'hF;
        end else begin
            ack_q <= printer_ack_n_i;
            if (printer_ack_n_i && !ack_q) begin
                since_ack_q <= 4'h0;
            end else if (since_ack_q != 4'hF) begin
                since_ack_q <= since_ack_q + 4'h1;
            end
        end
    end

    a_reset_quiet: assert property ($rose(rstn_i) |-> host_data_oe_n_o
        && !ack_irq_o && !printer_strobe_o && !printer_restart_o)
        else $error("Outputs not at reset values after reset.");
    a_deselect_idle: assert property (port_select_n_i[*8]
        |-> host_data_oe_n_o) else $error("Host bus driven while deselected.");
    a_read_answer: assert property ($fell(host_read_strobe_n_i)
        && !port_select_n_i |-> ##[1:6] !host_data_oe_n_o)
        else $error("Selected read got no answer.");
    a_compat_drive: assert property (
        (!extended_mode_pin_i && !simple_variant_i)[*6]
        |-> !printer_data_lines_oe_n_o)
        else $error("Data pins released in compatible mode.");
    a_simple_release: assert property (
        (simple_variant_i && latch_drive_enable_n_i)[*6]
        |-> printer_data_lines_oe_n_o)
        else $error("Data pins driven with latch drive off.");
    a_simple_drive: assert property (
        (simple_variant_i && !latch_drive_enable_n_i)[*6]
        |-> !printer_data_lines_oe_n_o)
        else $error("Data pins released with latch drive on.");
    a_irq_cause: assert property ($rose(ack_irq_o)
        |-> since_ack_q <= 4'h7)
        else $error("Interrupt rose without acknowledge release.");
    a_read_clears: assert property (ack_irq_o
        && $fell(host_read_strobe_n_i) && !port_select_n_i
        && host_addr_i == PPG_ADDR_STATUS |-> ##[2:8] !ack_irq_o)
        else $error("Status read did not clear interrupt.");
    a_gp_inputs: assert property (gp_lines_oe_n_o[2:0] == 3'h7)
        else $error("General input line driven.");
endmodule : ppg_top_asserts

bind ppg_top ppg_top_asserts i_chk (
    .core_clk_i,
    .rstn_i,
    .port_select_n_i,
    .host_read_strobe_n_i,
    .host_addr_i,
    .host_data_oe_n_o,
    .extended_mode_pin_i,
    .simple_variant_i,
    .latch_drive_enable_n_i,
    .printer_data_lines_oe_n_o,
    .printer_strobe_o,
    .printer_restart_o,
    .printer_ack_n_i,
    .ack_irq_o,
    .gp_lines_oe_n_o
);

// [dv/ppg_printer_model.sv]
// Purpose: Printer on the far side of the data and handshake lines.
// Assumes: Strobe output of the port is a registered level.
// Notes: Answers each strobe with busy and a short acknowledge pulse.
`timescale 1ns/1ns
module ppg_printer_model (
    // Clock
    input wire logic core_clk_i,
    // Device side
    input wire logic [7:0] dev_data_i,
    input wire logic dev_oe_n_i,
    input wire logic strobe_i,
    // Printer side
    input wire logic [7:0] drive_val_i,
    output logic [7:0] lines_o,
    output logic ack_n_o,
    output logic busy_o
);
    // Printer drives the lines whenever the port lets go of them.
    assign lines_o = dev_oe_n_i ? drive_val_i : dev_data_i;

    initial begin
        ack_n_o = 1'b1;
        busy_o = 1'b0;
        forever begin
            @(posedge strobe_i);
            #1 busy_o = 1'b1;
            repeat (4) @(posedge core_clk_i);
            #1 ack_n_o = 1'b0;
            repeat (4) @(posedge core_clk_i);
            #1 ack_n_o = 1'b1;
            busy_o = 1'b0;
        end
    end
endmodule : ppg_printer_model

// [dv/tb_printer_port_with_gpio.sv]
// Purpose: Self-checking bench for the printer port with general I/O.
// Assumes: Host strobes driven 1 ns after the clock edge.
// Notes: Register access through select, address and strobe tasks.
`timescale 1ns/1ns
module tb_printer_port_with_gpio;
    import ppg_pkg::*;
    logic core_clk_i, rstn_i, port_select_n_i, host_read_strobe_n_i;
    logic host_write_strobe_n_i, host_data_oe_n_o, extended_mode_pin_i;
    logic simple_variant_i, latch_drive_enable_n_i, gpio_config_done_i;
    logic printer_data_lines_oe_n_o, printer_strobe_o, auto_linefeed_o;
    logic printer_restart_o, printer_select_in_o, printer_fault_n_i;
    logic printer_online_i, paper_out_i, printer_ack_n_i, printer_busy_i;
    logic ack_irq_o;
    logic [1:0] host_addr_i;
    logic [7:0] host_data_i, host_data_o, printer_data_lines_i, rv;
    logic [7:0] printer_data_lines_o, pdrive;
    logic [6:0] gp_lines_i, gp_lines_o, gp_lines_oe_n_o, gp_ext;
    logic [7:0] cv [6] = '{8'h00, 8'h0B, 8'h05, 8'h06, 8'h0C, 8'h04};
    logic [3:0] cp [6] = '{4'h4, 4'hF, 4'h1, 4'h2, 4'h8, 4'h0};
    int mismatches = 0;
    int cmp_count = 0;
    wire logic [7:0] ctl_pins = {4'h0, printer_select_in_o,
        printer_restart_o, auto_linefeed_o, printer_strobe_o};
    assign gp_lines_i = (gp_lines_oe_n_o & gp_ext) |
        (~gp_lines_oe_n_o & gp_lines_o);

    ppg_top i_dut (.core_clk_i, .rstn_i, .port_select_n_i,
        .host_read_strobe_n_i, .host_write_strobe_n_i, .host_addr_i,
        .host_data_i, .host_data_o, .host_data_oe_n_o, .extended_mode_pin_i,
        .simple_variant_i, .latch_drive_enable_n_i, .gpio_config_done_i,
        .printer_data_lines_i, .printer_data_lines_o,
        .printer_data_lines_oe_n_o, .printer_strobe_o, .auto_linefeed_o,
        .printer_restart_o, .printer_select_in_o, .printer_fault_n_i,
        .printer_online_i, .paper_out_i, .printer_ack_n_i, .printer_busy_i,
        .ack_irq_o, .gp_lines_i, .gp_lines_o, .gp_lines_oe_n_o);

    ppg_printer_model i_prn (.core_clk_i, .dev_data_i(printer_data_lines_o),
        .dev_oe_n_i(printer_data_lines_oe_n_o), .strobe_i(printer_strobe_o),
        .drive_val_i(pdrive), .lines_o(printer_data_lines_i),
        .ack_n_o(printer_ack_n_i), .busy_o(printer_busy_i));

    always #2 core_clk_i = ~core_clk_i;

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        cmp_count++;
        if (got !== exp) begin
            mismatches++;
            $display("CHECK FAILED at %0t: got %h, expected %h", $time, got,
                exp);
        end
    endtask : chk

    task automatic cyc(input int n);
        repeat (n) @(posedge core_clk_i);
        #1;
    endtask : cyc

    task automatic hw(input logic [1:0] a, input logic [7:0] d);
        host_addr_i = a;
        host_data_i = d;
        port_select_n_i = 1'b0;
        cyc(1);
        host_write_strobe_n_i = 1'b0;
        cyc(4);
        host_write_strobe_n_i = 1'b1;
        cyc(4);
        port_select_n_i = 1'b1;
        cyc(4);
    endtask : hw

    task automatic hr(input logic [1:0] a, output logic [7:0] d);
        host_addr_i = a;
        port_select_n_i = 1'b0;
        cyc(1);
        host_read_strobe_n_i = 1'b0;
        cyc(6);
        d = (host_data_oe_n_o === 1'b0) ? host_data_o : 8'hXX;
        host_read_strobe_n_i = 1'b1;
        cyc(4);
        port_select_n_i = 1'b1;
        cyc(4);
    endtask : hr

    task automatic rd(input logic [1:0] a, input logic [7:0] exp);
        logic [7:0] d;
        hr(a, d);
        chk(d, exp);
    endtask : rd

    task automatic tally_and_finish();
        $display("Comparisons %0d, mismatches %0d", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : tally_and_finish

    // The tests need a few microseconds; this limit is far beyond them.
    initial begin
        #100000;
        mismatches++;
        tally_and_finish();
    end

    initial begin
        {core_clk_i, rstn_i, extended_mode_pin_i, simple_variant_i} = 4'h0;
        {port_select_n_i, host_read_strobe_n_i, host_write_strobe_n_i} = 3'h7;
        {latch_drive_enable_n_i, gpio_config_done_i, paper_out_i} = 3'h0;
        {printer_fault_n_i, printer_online_i} = 2'h3;
        {host_addr_i, host_data_i} = {2'h0, 8'h00};
        {pdrive, gp_ext} = {8'h3C, 7'h05};
        cyc(3);
        rstn_i = 1'b1;
        cyc(4);
        rd(PPG_ADDR_CTRL, 8'hE4);
        chk(ctl_pins, 8'h00);
        rd(PPG_ADDR_STATUS, 8'hDF);
        {printer_fault_n_i, paper_out_i} = 2'h1;
        rd(PPG_ADDR_STATUS, 8'hF7);
        hw(PPG_ADDR_DATA, 8'hA5);
        chk(printer_data_lines_o, 8'hA5);
        chk({7'h00, printer_data_lines_oe_n_o}, 8'h00);
        hw(PPG_ADDR_STATUS, 8'h00);
        rd(PPG_ADDR_DATA, 8'hA5);
        host_data_i = 8'h11;
        host_write_strobe_n_i = 1'b0;
        cyc(4);
        host_write_strobe_n_i = 1'b1;
        cyc(4);
        rd(PPG_ADDR_DATA, 8'hA5);
        rd(PPG_ADDR_STATUS, 8'hF7);
        for (int i = 0; i < 6; i++) begin
            hw(PPG_ADDR_CTRL, cv[i]);
            chk(ctl_pins, {4'h0, cp[i]});
            rd(PPG_ADDR_CTRL, cv[i] | 8'hE0);
        end
        chk({7'h00, ack_irq_o}, 8'h00);
        rd(PPG_ADDR_STATUS, 8'hF7);
        hw(PPG_ADDR_CTRL, 8'h14);
        hw(PPG_ADDR_CTRL, 8'h15);
        hw(PPG_ADDR_CTRL, 8'h14);
        chk({7'h00, ack_irq_o}, 8'h01);
        hr(PPG_ADDR_STATUS, rv);
        chk({7'h00, ack_irq_o}, 8'h00);
        rd(PPG_ADDR_STATUS, 8'hF7);
        extended_mode_pin_i = 1'b1;
        hw(PPG_ADDR_CTRL, 8'h24);
        chk({7'h00, printer_data_lines_oe_n_o}, 8'h01);
        rd(PPG_ADDR_DATA, 8'h3C);
        hw(PPG_ADDR_DATA, 8'h66);
        chk({7'h00, printer_data_lines_oe_n_o}, 8'h01);
        extended_mode_pin_i = 1'b0;
        cyc(6);
        chk(printer_data_lines_o, 8'h66);
        chk({7'h00, printer_data_lines_oe_n_o}, 8'h00);
        extended_mode_pin_i = 1'b1;
        hw(PPG_ADDR_CTRL, 8'h04);
        rd(PPG_ADDR_DATA, 8'h66);
        {extended_mode_pin_i, simple_variant_i, latch_drive_enable_n_i} = 3'h3;
        cyc(6);
        rd(PPG_ADDR_DATA, 8'h3C);
        latch_drive_enable_n_i = 1'b0;
        cyc(6);
        chk(printer_data_lines_o, 8'h66);
        chk({7'h00, printer_data_lines_oe_n_o}, 8'h00);
        simple_variant_i = 1'b0;
        rd(PPG_ADDR_GPIO, 8'h00);
        gpio_config_done_i = 1'b1;
        hw(PPG_ADDR_GPIO, 8'h7F);
        rd(PPG_ADDR_GPIO, 8'h7D);
        chk({1'b0, gp_lines_o} & 8'h78, 8'h78);
        chk({1'b0, gp_lines_oe_n_o}, 8'h07);
        hw(PPG_ADDR_GPIO, 8'h00);
        rd(PPG_ADDR_GPIO, 8'h05);
        chk({1'b0, gp_lines_oe_n_o}, 8'h1F);
        tally_and_finish();
    end
endmodule : tb_printer_port_with_gpio
